/* logic/dov_params.svh */
// Constants of the disk operator and variant decoder.
// What this block does
// - Wait clear and exchange busy: end with result bits 0,1,16 = 110.
// - Read, write, initialize, relocate: restore-inhibit variant suppresses auto restore.
// - Extended read returns all words; result bits 16,21,22,23 = 0001.
// - Spare select 000 is normal; 1-5 picks a head 0 spare.
// - Raw and verify clear: spare select 1 offsets in, 5 offsets out.
// - Verify runs as a read but sends the verify command.
// - Four-bit unit field picks one of sixteen spindles.
// - Diagnostic read passes 64 status bits from the controller onward.
// - Status bits 1-23: cylinder, head, segment weights, cylinder change.
// - Status bits 24-45: op, unit, spare, faults; rest reserved.
// - Write takes ascending words from start to end, zero-pads last.
// - Each written sector is 90 data words then two dummy words.
// - Initialize formats from index; default sync plus address, 45 times.
// - Initialize and relocate run as writes of one data word.
// - Initialize whole-pack variant formats pack, else one track.
// - Initialize pattern variant uses first 16 bits, 90 times per sector.
// - Relocate flags the sector and writes the spare, 45 repeats.
// - Relocate pattern variant uses first 16 bits, repeated 90 times.
// - Test codes 0000, 1000, 0100 return a result or fetch next.
// - Test 0001 takes drive off-line; 0010 pauses, suppresses bit 16.
// - Pause waits 1 to 2 ms, then service request without bit 16.
// - Operator: op in top three bits, unit in low four bits.
`ifndef DOV_PARAMS_SVH
`define DOV_PARAMS_SVH
`define OFS_OPER     5'h00
`define OFS_ADDR_A   5'h04
`define OFS_ADDR_B   5'h08
`define OFS_RESULT   5'h0c
`define OFS_STATE    5'h10
`define OFS_DIAG_LOC 5'h14
`define OFS_DIAG_ID  5'h18
`define OP_MSB   23
`define OP_LSB   21
`define V_WAIT   20
`define V_NORST  19
`define V_EXT    18
`define V_RAW    17
`define V_PV     16
`define V_DIAG   15
`define V_PAT    14
`define SPR_MSB  13
`define SPR_LSB  11
`define TC_MSB   10
`define TC_LSB   7
`define OPC_READ  3'h1
`define OPC_WRITE 3'h2
`define OPC_INIT  3'h3
`define OPC_RELOC 3'h4
`define OPC_TEST  3'h5
`define OPC_PAUSE 3'h6
`define TC_NOW   4'h0
`define TC_RDY   4'h8
`define TC_NRDY  4'h4
`define TC_OFFL  4'h1
`define TC_PAUSE 4'h2
`define SPR_IN   3'h1
`define SPR_OUT  3'h5
`define SEC_DATA 7'h5a
`define SEC_LAST 7'h5b
`define RD_LAST  7'h5c
`define SYNC_REP 7'h2d
`define PAT_REP  7'h5a
`define DIAG_WDS 7'h04
`define WORD_BITS 24'h10
`define CLK_NS   100
`define PAUSE_NS 1000000
`define PAUSE_CYC ((`PAUSE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

/* logic/dov_pkg.sv */
// Types shared by the disk operator and variant decoder.
package dov_pkg;
    typedef enum logic [2:0] {
        EC_READ    = 3'b000,
        EC_VERIFY  = 3'b001,
        EC_WRITE   = 3'b010,
        EC_INIT    = 3'b011,
        EC_RELOC   = 3'b100,
        EC_DIAG    = 3'b101,
        EC_OFFLINE = 3'b110
    } dov_ecop_t;
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0000,
        S_XCHK  = 4'b0001,
        S_ISSUE = 4'b0010,
        S_FETCH = 4'b0011,
        S_MWAIT = 4'b0100,
        S_SEND  = 4'b0101,
        S_RUN   = 4'b0110,
        S_TEST  = 4'b0111,
        S_PAUSE = 4'b1000,
        S_END   = 4'b1001
    } dov_state_t;
    typedef struct packed {
        dov_ecop_t  op;
        logic [3:0] unit;
        logic [2:0] spare;
        logic       offs_in;
        logic       offs_out;
        logic       no_restore;
        logic       whole_pack;
        logic       use_pattern;
        logic [6:0] rep;
    } dov_cmd_t;
endpackage

/* logic/dov_decoder.sv */
// Operator and variant interpreter between I/O driver and disk controller.
`timescale 1ns/100ps
`include "dov_params.svh"
module dov_decoder #(
    parameter int P_PAUSE_CYC = `PAUSE_CYC
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic [4:0]       i_addr,
    input  wire logic [31:0]      i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic      [31:0]      o_rdata,
    input  wire logic             i_xbusy,
    input  wire logic             i_drv_present,
    input  wire logic             i_drv_ready,
    input  wire logic             i_drv_seek,
    input  wire logic             i_drv_avail,
    output logic                  o_ec_start,
    output dov_pkg::dov_cmd_t     o_ec_cmd,
    output logic                  o_ec_wvalid,
    output logic      [15:0]      o_ec_wdata,
    input  wire logic             i_ec_wtake,
    input  wire logic             i_ec_rvalid,
    input  wire logic [15:0]      i_ec_rdata,
    input  wire logic             i_ec_done,
    input  wire logic [15:0]      i_ec_result,
    output logic                  o_mem_rd,
    output logic      [23:0]      o_mem_addr,
    input  wire logic             i_mem_ack,
    input  wire logic [15:0]      i_mem_data,
    output logic                  o_rd_valid,
    output logic      [15:0]      o_rd_data,
    output logic                  o_sr,
    output logic                  o_next,
    output logic      [23:0]      o_result
);
    import dov_pkg::*;

    localparam int PW = $clog2(P_PAUSE_CYC + 1);

    // ------------------------------------------------------------
    // Operator fields
    // ------------------------------------------------------------
    dov_state_t  st_q;
    logic [23:0] oper_q;
    logic [23:0] b_q;
    logic [6:0]  wcnt_q;
    logic [6:0]  rcnt_q;
    logic [63:0] diag_q;
    logic [PW-1:0] pcnt_q;

    // Op in the top three bits, unit in the low four.
    logic [2:0] opc;
    logic [3:0] unit;
    logic [2:0] spr;
    logic [3:0] tcode;
    assign opc   = oper_q[`OP_MSB:`OP_LSB];
    assign unit  = oper_q[3:0];
    assign spr   = oper_q[`SPR_MSB:`SPR_LSB];
    assign tcode = oper_q[`TC_MSB:`TC_LSB];

    // Decoded operator classes.
    logic is_rd;
    logic is_wr;
    logic one_wd;
    logic rw_op;
    logic ext;
    logic diag;
    logic go;
    logic active;
    assign is_rd  = (opc == `OPC_READ);
    assign one_wd = (opc == `OPC_INIT) || (opc == `OPC_RELOC);
    assign is_wr  = (opc == `OPC_WRITE) || one_wd;
    assign rw_op  = is_rd || is_wr;
    assign ext    = is_rd && oper_q[`V_EXT];
    assign diag   = is_rd && oper_q[`V_DIAG];
    assign go     = i_wr && (i_addr == `OFS_OPER) && (st_q == S_IDLE);
    assign active = (st_q == S_FETCH) || (st_q == S_MWAIT)
                 || (st_q == S_SEND) || (st_q == S_RUN);

    // A memory word is needed for write data slots still below the end; init and relocate need one only with the pattern variant.
    logic need_mem;
    logic [23:0] rem;
    assign rem = b_q - o_mem_addr;
    assign need_mem = (o_mem_addr < b_q)
                   && (one_wd ? oper_q[`V_PAT] : (wcnt_q < `SEC_DATA));

    // Test outcome for the drive status probes.
    logic drv_ok;
    assign drv_ok = i_drv_present && i_drv_ready && !i_drv_seek;

    // ------------------------------------------------------------
    // Result mapping
    // ------------------------------------------------------------
    // Maps a controller result word onto the 24-bit result.
    function automatic logic [23:0] map_res(input logic [15:0] c);
        logic [23:0] r;
        r = 24'h000000;
        r[0]  = 1'b1;
        r[2]  = c[3] | c[4] | c[9];
        r[3]  = c[0];
        r[4]  = c[15];
        r[6]  = c[1];
        r[9]  = c[6];
        r[10] = c[7];
        r[11] = c[8];
        r[15] = c[14];
        r[1]  = |{r[15:9], r[7:3]};
        r[16] = 1'b1;
        return r;
    endfunction

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Main operation sequence.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= S_IDLE;
        end
        else
        begin
            unique case (st_q)
                S_IDLE:
                begin
                    if (go)
                    begin
                        if (i_wdata[`OP_MSB:`OP_LSB] == `OPC_PAUSE)
                            st_q <= S_PAUSE;
                        else if (i_wdata[`OP_MSB:`OP_LSB] == `OPC_TEST)
                            st_q <= S_TEST;
                        else
                            st_q <= S_XCHK;
                    end
                end
                S_XCHK:
                begin
                    // Busy exchange: wait, or give up at once.
                    if (!i_xbusy)
                        st_q <= S_ISSUE;
                    else if (!oper_q[`V_WAIT])
                        st_q <= S_END;
                end
                S_ISSUE:
                    st_q <= is_wr ? S_FETCH : S_RUN;
                S_FETCH:
                begin
                    if (i_ec_done)
                        st_q <= S_END;
                    else
                        st_q <= need_mem ? S_MWAIT : S_SEND;
                end
                S_MWAIT:
                begin
                    if (i_ec_done)
                        st_q <= S_END;
                    else if (i_mem_ack)
                        st_q <= S_SEND;
                end
                S_SEND:
                begin
                    if (i_ec_done)
                        st_q <= S_END;
                    else if (i_ec_wtake)
                        st_q <= one_wd ? S_RUN : S_FETCH;
                end
                S_RUN:
                begin
                    if (i_ec_done)
                        st_q <= S_END;
                end
                S_TEST:
                begin
                    // Conditional results fall through to the next one.
                    unique case (tcode)
                        `TC_RDY:   st_q <= drv_ok ? S_END : S_IDLE;
                        `TC_NRDY:  st_q <= drv_ok ? S_IDLE : S_END;
                        `TC_OFFL:
                            st_q <= (i_drv_present && i_drv_avail)
                                  ? S_ISSUE : S_END;
                        `TC_PAUSE: st_q <= S_PAUSE;
                        default:   st_q <= S_END;
                    endcase
                end
                S_PAUSE:
                begin
                    if (pcnt_q == PW'(P_PAUSE_CYC - 1))
                        st_q <= S_END;
                end
                S_END:
                    st_q <= S_IDLE;
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end

    // Operator and end address registers; operator writes start work.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            oper_q <= 24'h000000;
            b_q    <= 24'h000000;
        end
        else
        begin
            if (go)
                oper_q <= i_wdata[23:0];
            if (i_wr && (i_addr == `OFS_ADDR_B) && (st_q == S_IDLE))
                b_q <= i_wdata[23:0];
        end
    end

    // Memory address walks upward one word at a time.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_mem_addr <= 24'h000000;
            o_mem_rd   <= 1'b0;
        end
        else
        begin
            o_mem_rd <= (st_q == S_FETCH) && need_mem && !i_ec_done;
            if (i_wr && (i_addr == `OFS_ADDR_A) && (st_q == S_IDLE))
                o_mem_addr <= i_wdata[23:0];
            else if ((st_q == S_MWAIT) && i_mem_ack)
                o_mem_addr <= o_mem_addr + `WORD_BITS;
        end
    end

    // Outgoing data word: memory data, zero fill, or dummy.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_ec_wdata  <= 16'h0000;
            o_ec_wvalid <= 1'b0;
            wcnt_q      <= 7'h00;
        end
        else
        begin
            if (go)
                wcnt_q <= 7'h00;
            if ((st_q == S_FETCH) && !need_mem)
                o_ec_wdata <= 16'h0000;
            else if ((st_q == S_MWAIT) && i_mem_ack)
            begin
                // Bits past the end address go out as zero.
                if (rem < `WORD_BITS)
                    o_ec_wdata <= i_mem_data
                                & ~(16'hffff >> rem[3:0]);
                else
                    o_ec_wdata <= i_mem_data;
            end
            if (((st_q == S_FETCH) && !need_mem && !i_ec_done)
                || ((st_q == S_MWAIT) && i_mem_ack && !i_ec_done))
                o_ec_wvalid <= 1'b1;
            else if ((st_q == S_SEND) && (i_ec_wtake || i_ec_done))
                o_ec_wvalid <= 1'b0;
            if ((st_q == S_SEND) && i_ec_wtake)
                wcnt_q <= (wcnt_q == `SEC_LAST)
                        ? 7'h00 : wcnt_q + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Controller command
    // ------------------------------------------------------------
    // Builds the controller command from the variants.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_ec_start <= 1'b0;
            o_ec_cmd   <= '0;
        end
        else
        begin
            o_ec_start <= (st_q == S_ISSUE);
            if (st_q == S_ISSUE)
            begin
                o_ec_cmd.unit <= unit;
                o_ec_cmd.no_restore <= rw_op
                                     && oper_q[`V_NORST];
                o_ec_cmd.whole_pack <= (opc == `OPC_INIT)
                                     && oper_q[`V_PV];
                o_ec_cmd.use_pattern <= one_wd
                                      && oper_q[`V_PAT];
                o_ec_cmd.rep <= !one_wd ? 7'h00
                              : oper_q[`V_PAT] ? `PAT_REP
                              : `SYNC_REP;
                // Spare select only with raw, verify or relocate.
                o_ec_cmd.spare <= ((is_rd && (oper_q[`V_RAW]
                                  || oper_q[`V_PV]))
                                  || (opc == `OPC_RELOC))
                                ? spr : 3'h0;
                o_ec_cmd.offs_in <= is_rd && !oper_q[`V_RAW]
                                 && !oper_q[`V_PV]
                                 && (spr == `SPR_IN);
                o_ec_cmd.offs_out <= is_rd && !oper_q[`V_RAW]
                                  && !oper_q[`V_PV]
                                  && (spr == `SPR_OUT);
                if (opc == `OPC_TEST)
                    o_ec_cmd.op <= EC_OFFLINE;
                else if (opc == `OPC_WRITE)
                    o_ec_cmd.op <= EC_WRITE;
                else if (opc == `OPC_INIT)
                    o_ec_cmd.op <= EC_INIT;
                else if (opc == `OPC_RELOC)
                    o_ec_cmd.op <= EC_RELOC;
                else if (diag)
                    o_ec_cmd.op <= EC_DIAG;
                else if (oper_q[`V_PV])
                    o_ec_cmd.op <= EC_VERIFY;
                else
                    o_ec_cmd.op <= EC_READ;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Forwards read words; plain reads drop check and result words.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rcnt_q     <= 7'h00;
            o_rd_valid <= 1'b0;
            o_rd_data  <= 16'h0000;
            diag_q     <= 64'h0;
        end
        else
        begin
            o_rd_valid <= 1'b0;
            if (go)
                rcnt_q <= 7'h00;
            else if (active && is_rd && i_ec_rvalid)
            begin
                rcnt_q <= (!diag && (rcnt_q == `RD_LAST))
                        ? 7'h00 : rcnt_q + 7'h01;
                o_rd_data  <= i_ec_rdata;
                o_rd_valid <= ext || (diag && rcnt_q < `DIAG_WDS)
                           || (!diag && rcnt_q < `SEC_DATA);
                if (diag && (rcnt_q < `DIAG_WDS))
                    diag_q <= {diag_q[47:0], i_ec_rdata};
            end
        end
    end

    // Pause timer, at least 1 ms.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            pcnt_q <= '0;
        else if (st_q == S_PAUSE)
            pcnt_q <= pcnt_q + PW'(1);
        else
            pcnt_q <= '0;
    end

    // ------------------------------------------------------------
    // Result and service request
    // ------------------------------------------------------------
    // Assembles the 24-bit result for each way of ending.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_result <= 24'h000000;
            o_sr     <= 1'b0;
            o_next   <= 1'b0;
        end
        else
        begin
            o_sr   <= (st_q == S_END);
            o_next <= (st_q == S_TEST) && (((tcode == `TC_RDY)
                      && !drv_ok) || ((tcode == `TC_NRDY)
                      && drv_ok));
            if (go)
                o_result <= 24'h000000;
            else if ((st_q == S_XCHK) && i_xbusy
                     && !oper_q[`V_WAIT])
                o_result <= 24'h000003;
            else if (active && i_ec_done)
            begin
                o_result <= map_res(i_ec_result);
                if (ext)
                begin
                    o_result[16] <= 1'b0;
                    o_result[21] <= 1'b0;
                    o_result[22] <= 1'b0;
                    o_result[23] <= 1'b1;
                end
            end
            else if (st_q == S_TEST)
            begin
                o_result[0]  <= 1'b1;
                o_result[2]  <= !i_drv_ready;
                o_result[12] <= i_drv_seek;
                o_result[16] <= (tcode != `TC_PAUSE);
            end
            else if ((st_q == S_PAUSE) && (opc == `OPC_PAUSE))
                o_result <= 24'h000001;
        end
    end

    // Register reads answer one cycle after the strobe, else zero.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_rdata <= 32'h00000000;
        else if (i_rd)
        begin
            unique case (i_addr)
                `OFS_OPER:   o_rdata <= {8'h00, oper_q};
                `OFS_ADDR_A: o_rdata <= {8'h00, o_mem_addr};
                `OFS_ADDR_B: o_rdata <= {8'h00, b_q};
                `OFS_RESULT: o_rdata <= {8'h00, o_result};
                `OFS_STATE:
                    o_rdata <= {27'h0, st_q, st_q != S_IDLE};
                // Cylinder, head, segment, cylinder change.
                `OFS_DIAG_LOC:
                    o_rdata <= {10'h0, diag_q[63:54], diag_q[53:49],
                                diag_q[47:42], diag_q[41]};
                // Op, unit, spare select, fault bits.
                `OFS_DIAG_ID:
                    o_rdata <= {10'h0, diag_q[40:38], diag_q[37:35],
                                diag_q[34:32], diag_q[31:19]};
                default:     o_rdata <= 32'h00000000;
            endcase
        end
        else
            o_rdata <= 32'h00000000;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    busy_end_a: assert property (
        (st_q == S_XCHK) && i_xbusy && !oper_q[`V_WAIT]
        |-> ##2 o_sr && o_result[0] && o_result[1] && !o_result[16])
        else $error("busy exchange did not end with 110");

    busy_wait_a: assert property (
        (st_q == S_XCHK) && i_xbusy && oper_q[`V_WAIT]
        |=> (st_q == S_XCHK) && !o_ec_start)
        else $error("wait variant did not hold the operation");

    restore_flag_a: assert property (
        o_ec_start && rw_op |-> o_ec_cmd.no_restore == oper_q[`V_NORST])
        else $error("restore inhibit not passed on");

    ext_result_a: assert property (
        active && i_ec_done && ext |-> ##2 o_sr
        && (o_result[23:21] == 3'h4) && !o_result[16])
        else $error("extended read end bits wrong");

    offset_read_a: assert property (
        o_ec_start && is_rd && !oper_q[`V_RAW] && !oper_q[`V_PV]
        |-> o_ec_cmd.offs_in == (spr == `SPR_IN)
        && o_ec_cmd.offs_out == (spr == `SPR_OUT))
        else $error("offset read request wrong");

    verify_op_a: assert property (
        o_ec_start && is_rd && oper_q[`V_PV] && !diag
        |-> o_ec_cmd.op == EC_VERIFY)
        else $error("verify not sent to controller");

    unit_sel_a: assert property (
        o_ec_start |-> o_ec_cmd.unit == $past(oper_q[3:0]))
        else $error("unit field not passed on");

    dummy_zero_a: assert property (
        o_ec_wvalid && !one_wd && (wcnt_q >= `SEC_DATA)
        |-> (o_ec_wdata == 16'h0000) && (wcnt_q <= `SEC_LAST))
        else $error("dummy word not zero or sector too long");

    pause_hold_a: assert property (
        $rose(st_q == S_PAUSE) |-> (st_q == S_PAUSE)[*8] ##1 !o_sr)
        else $error("pause ended too early");

    pause_nobit_a: assert property (
        o_sr && $past(st_q == S_END, 1) && (opc == `OPC_PAUSE)
        |-> !o_result[16] && o_result[0])
        else $error("pause result bit 16 not suppressed");
endmodule

/* test/dov_far_model.sv */
// Far-side model: disk electronics controller plus memory port.
`timescale 1ns/100ps
module dov_far_model (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_ec_wvalid,
    input  wire logic        i_mem_rd,
    input  wire logic        i_one,
    output logic             o_ec_wtake,
    output logic             o_ec_done,
    output logic             o_mem_ack,
    output logic [15:0]      o_mem_data,
    output logic [7:0]       o_takes
);
    // Takes each offered word, answers fetches, ends after one sector.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            {o_ec_wtake, o_ec_done, o_mem_ack} <= 3'h0;
            o_mem_data <= 16'h0;
            o_takes <= 8'h0;
        end
        else
        begin
            o_ec_wtake <= i_ec_wvalid && !o_ec_wtake;
            o_mem_ack <= i_mem_rd;
            o_mem_data <= i_mem_rd ? 16'h5a3c : ~o_mem_data;
            o_takes <= o_takes + {7'h0, o_ec_wtake};
            // One-word operations end on their first take.
            o_ec_done <= o_ec_wtake
                      && (i_one || (o_takes == 8'h5b));
        end
    end
endmodule

/* test/test_dov_decoder.sv */
// Self-checking bench for the disk operator and variant decoder.
`timescale 1ns/100ps
`include "dov_params.svh"
module test_dov_decoder;
    import dov_pkg::*;
    typedef struct packed {logic [23:0] op; logic busy, rdy, sr;} dov_row_t;
    logic        i_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0;
    logic        i_xbusy = 0, i_rdy = 0, i_seek = 0;
    logic [4:0]  i_addr = 5'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [23:0] o_result, mem_addr;
    logic [15:0] ec_wdata, rd_data, mem_data;
    logic        o_sr, o_next, ec_start, wvalid, wtake, done, mem_rd, ack, rdv;
    logic [7:0]  takes;
    dov_cmd_t    cmd;
    int          n_mismatch = 0, num_checks = 0, n;
    dov_row_t    rows [7] = '{'{24'ha00005, 0, 0, 1}, '{24'ha00406, 0, 0, 0},
        '{24'ha00407, 0, 1, 1}, '{24'ha00208, 0, 1, 0},
        '{24'ha0020a, 0, 0, 1}, '{24'ha0010b, 0, 1, 1},
        '{24'h400003, 1, 1, 1}};
    dov_decoder #(.P_PAUSE_CYC(20)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_xbusy(i_xbusy), .i_drv_present(i_rdy),
        .i_drv_ready(i_rdy), .i_drv_seek(i_seek), .i_drv_avail(1'b1),
        .o_ec_start(ec_start), .o_ec_cmd(cmd), .o_ec_wvalid(wvalid),
        .o_ec_wdata(ec_wdata), .i_ec_wtake(wtake), .i_ec_rvalid(1'b0),
        .i_ec_rdata(16'h0), .i_ec_done(done), .i_ec_result(16'h0),
        .o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .i_mem_ack(ack),
        .i_mem_data(mem_data), .o_rd_valid(rdv), .o_rd_data(rd_data),
        .o_sr(o_sr), .o_next(o_next), .o_result(o_result));
    dov_far_model far_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ec_wvalid(wvalid),
        .i_mem_rd(mem_rd), .o_ec_wtake(wtake), .o_ec_done(done),
        .i_one((cmd.op == EC_INIT) || (cmd.op == EC_RELOC)),
        .o_mem_ack(ack), .o_mem_data(mem_data), .o_takes(takes));
    // Free-running 10 MHz clock.
    initial forever #50 i_clk = ~i_clk;
    task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(logic [4:0] a, logic [23:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= {8'h0, d};
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(logic [4:0] a, logic [23:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk("rdata", o_rdata[23:0], e);
    endtask
    // Waits for a service request or a next-descriptor pulse, bounded.
    task automatic wait_end(int lim);
        n = 0;
        do
        begin
            @(posedge i_clk);
            #1 n++;
            if (n > lim)
            begin
                n_mismatch++;
                conclude();
            end
        end while (!(o_sr || o_next));
    endtask
    // Table of operators first, then wait, write and pause by hand.
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        #1 chk("rst", o_result, 24'h0);
        foreach (rows[i])
        begin
            i_xbusy <= rows[i].busy;
            i_rdy <= rows[i].rdy;
            wr(`OFS_OPER, rows[i].op);
            wait_end(100);
            chk("sr", {23'h0, o_sr}, {23'h0, rows[i].sr});
        end
        chk("busy", o_result, 24'h000003);
        rd(`OFS_RESULT, 24'h000003);
        rd(5'h1c, 24'h0);
        // A seeking drive is not ready for test code 1000.
        i_rdy <= 1'b1;
        i_seek <= 1'b1;
        wr(`OFS_OPER, 24'ha00406);
        wait_end(100);
        chk("seek", {22'h0, o_sr, o_next}, 24'h1);
        i_seek <= 1'b0;
        wr(`OFS_ADDR_A, 24'h0);
        wr(`OFS_ADDR_B, 24'h0005a0);
        wr(`OFS_OPER, 24'h500009);
        repeat (20) @(posedge i_clk);
        chk("held", {16'h0, takes}, 24'h0);
        i_xbusy <= 1'b0;
        wait_end(3000);
        chk("words", {16'h0, takes}, 24'h00005c);
        chk("ecop", {21'h0, cmd.op}, {21'h0, EC_WRITE});
        chk("unit", {20'h0, cmd.unit}, 24'h9);
        chk("enda", mem_addr, 24'h0005a0);
        // Relocate onto spare 5, the first spare to hand out.
        wr(`OFS_OPER, 24'h802802);
        wait_end(200);
        chk("spare", {21'h0, cmd.spare}, 24'h5);
        chk("reloc", {21'h0, cmd.op}, {21'h0, EC_RELOC});
        chk("rep", {17'h0, cmd.rep}, 24'h00002d);
        chk("one", {16'h0, takes}, 24'h00005d);
        chk("relsr", {23'h0, o_sr}, 24'h1);
        wr(`OFS_OPER, 24'hc00000);
        wait_end(100);
        chk("pause", {23'h0, n >= 20 && n <= 45}, 24'h1);
        chk("bit16", {23'h0, o_result[16]}, 24'h0);
        // Reset in the middle of a pause returns everything to idle.
        wr(`OFS_OPER, 24'hc00000);
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        #1 chk("rst2", o_result, 24'h0);
        rd(`OFS_STATE, 24'h0);
        conclude();
    end
endmodule
